// File: verilog/cpm_comparator_pin_mux.v
// Comparator control registers, change flags and shared pin selection
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/10ps
`include "cpm_defs.vh"

module cpm_comparator_pin_mux (
    // Clock and reset
    input  wire                      ref_clk_in,
    input  wire                      srst_in,
    // Register port
    input  wire [`CPM_ADDR_W-1:0]    reg_addr_in,
    input  wire [`CPM_DATA_W-1:0]    reg_wdata_in,
    input  wire                      reg_wr_in,
    input  wire                      reg_rd_in,
    output wire [`CPM_DATA_W-1:0]    reg_rdata_out,
    // Core mode and option settings
    input  wire                      mouse_mode_in,
    input  wire                      counter_a_second_input_en_in,
    input  wire                      counter_b_second_input_en_in,
    input  wire                      counter_a_input_select_in,
    input  wire                      counter_b_input_select_in,
    input  wire                      timer_source_select_in,
    input  wire [2:0]                osc_option_in,
    // Analog comparators
    input  wire [`CPM_NCMP-1:0]      cmp_raw_in,
    output wire [`CPM_NCMP-1:0]      cmp_on_out,
    output wire [7:0]                cmp_neg_source_out,
    output wire [`CPM_NCMP-1:0]      cmp_change_flag_out,
    output wire [`CPM_NCMP-1:0]      cmp_drive_out,
    // Comparator output pins
    output wire [`CPM_FN_W-1:0]      port5_line1_fn_out,
    output wire [`CPM_FN_W-1:0]      port5_line2_fn_out,
    output wire [`CPM_FN_W-1:0]      port6_line3_fn_out,
    output wire [`CPM_FN_W-1:0]      port6_line4_fn_out,
    // Positive input pins
    output wire [`CPM_FN_W-1:0]      port5_line0_fn_out,
    output wire [`CPM_FN_W-1:0]      port5_line3_fn_out,
    output wire [`CPM_FN_W-1:0]      port6_line2_fn_out,
    output wire [`CPM_FN_W-1:0]      port6_line5_fn_out,
    // Negative input pins
    output wire [`CPM_FN_W-1:0]      port5_line5_fn_out,
    output wire [`CPM_FN_W-1:0]      port5_line4_fn_out,
    output wire [`CPM_FN_W-1:0]      port6_line1_fn_out,
    output wire [`CPM_FN_W-1:0]      port6_line6_fn_out
);

    // ***********************************************************
    // Declarations
    // ***********************************************************
    reg  [`CPM_DATA_W-1:0]     ctrl_reg;
    reg  [`CPM_CODE_MSB:0]     combine_reg;
    reg  [`CPM_CODE_MSB:0]     combine_next;
    reg  [`CPM_NCMP-1:0]       keep_reg;
    reg  [7:0]                 src_reg;
    reg  [`CPM_NCMP-1:0]       sync1_reg;
    reg  [`CPM_NCMP-1:0]       sync2_reg;
    reg  [`CPM_NCMP-1:0]       prev_reg;
    reg  [`CPM_NCMP-1:0]       flag_reg;
    reg  [`CPM_NCMP-1:0]       drive_reg;
    reg  [`CPM_DATA_W-1:0]     rdata_reg;
    reg  [`CPM_DATA_W-1:0]     rdata_next;
    reg  [`CPM_FN_W-1:0]       p51_fn;
    reg  [`CPM_FN_W-1:0]       p50_fn;
    reg  [`CPM_FN_W-1:0]       p55_fn;
    reg  [`CPM_FN_W-1:0]       p54_fn;
    reg  [`CPM_FN_W-1:0]       p61_fn;
    reg  [`CPM_FN_W-1:0]       p66_fn;

    wire [`CPM_NCMP-1:0]       cmp_on;
    wire [`CPM_NCMP-1:0]       route_bit;
    wire [`CPM_NCMP-1:0]       route_act;
    wire [`CPM_NCMP-1:0]       keep;
    wire [7:0]                 src;
    wire [`CPM_NCMP-1:0]       neg_used;
    wire [`CPM_NCMP-1:0]       change;
    wire [`CPM_NCMP-1:0]       flag_clr;
    wire [`CPM_NCMP-1:0]       flag_next;
    wire [`CPM_FN_W-1:0]       route_fn [0:`CPM_NCMP-1];
    wire [`CPM_FN_W-1:0]       pos_fn   [0:`CPM_NCMP-1];
    wire                       wr_ctrl;
    wire                       wr_comb;
    wire                       wr_flags;
    wire                       osc_is_port;

    // ***********************************************************
    // Register writes
    // ***********************************************************
    assign wr_ctrl  = reg_wr_in && (reg_addr_in == `CPM_ADDR_CTRL);
    assign wr_comb  = reg_wr_in && (reg_addr_in == `CPM_ADDR_COMBINE);
    assign wr_flags = reg_wr_in && (reg_addr_in == `CPM_ADDR_FLAGS);

    always @(posedge ref_clk_in) begin
        if (srst_in) begin
            ctrl_reg <= `CPM_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_reg <= reg_wdata_in;
        end
    end

    // Upper four bits are not stored and read back as zero.
    // The next code feeds the decoder, so the registered layout
    // lands on the same edge as the code itself.
    always @* begin
        combine_next = combine_reg;
        if (srst_in) begin
            combine_next = `CPM_COMBINE_RST;
        end else if (wr_comb) begin
            combine_next = reg_wdata_in[`CPM_CODE_MSB:`CPM_CODE_LSB];
        end
    end

    always @(posedge ref_clk_in) begin
        combine_reg <= combine_next;
    end

    assign cmp_on    = ctrl_reg[`CPM_ON_MSB:`CPM_ON_LSB];
    assign route_bit = ctrl_reg[`CPM_ROUTE_MSB:`CPM_ROUTE_LSB];
    assign route_act = route_bit & cmp_on;

    // ***********************************************************
    // Comparator output sampling and change flags
    // ***********************************************************
    // Comparators are asynchronous to the core clock
    always @(posedge ref_clk_in) begin
        if (srst_in) begin
            sync1_reg <= `CPM_ZERO4;
            sync2_reg <= `CPM_ZERO4;
            prev_reg  <= `CPM_ZERO4;
        end else begin
            sync1_reg <= cmp_raw_in;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    // Change only counts while the comparator is on; an idle
    // comparator output is not meaningful
    assign change   = (sync2_reg ^ prev_reg) & cmp_on;
    assign flag_clr = wr_flags ? reg_wdata_in[`CPM_NCMP-1:0] : `CPM_ZERO4;

    // Set beats clear in the same cycle so no event is lost
    assign flag_next = (flag_reg & ~flag_clr) | change;

    // Drive value lags the raw comparator by the two synchroniser
    // stages plus the drive register, three clocks, which software sees as a short output delay

    always @(posedge ref_clk_in) begin
        if (srst_in) begin
            flag_reg  <= `CPM_ZERO4;
            drive_reg <= `CPM_ZERO4;
        end else begin
            flag_reg  <= flag_next;
            drive_reg <= sync2_reg & route_act;
        end
    end

    // ***********************************************************
    // Negative input combining
    // ***********************************************************
    cpm_combine_decode cpm_combine_decode_inst (
        .code_in    (combine_next),
        .keep_out   (keep),
        .source_out (src)
    );

    // Layout held in flip-flops so the source output is registered
    always @(posedge ref_clk_in) begin
        keep_reg <= keep;
        src_reg  <= src;
    end

    // A pin is a negative input when some running comparator
    // takes its negative input from it
    genvar gi;
    generate
        for (gi = 0; gi < `CPM_NCMP; gi = gi + 1) begin : g_cmp
            assign neg_used[gi] = keep_reg[gi] && (
                (cmp_on[0] && (src_reg[1:0] == gi)) ||
                (cmp_on[1] && (src_reg[3:2] == gi)) ||
                (cmp_on[2] && (src_reg[5:4] == gi)) ||
                (cmp_on[3] && (src_reg[7:6] == gi)));
            assign route_fn[gi] = route_act[gi] ? `CPM_FN_CMP_OUT
                                                : `CPM_FN_PORT;
            assign pos_fn[gi]   = cmp_on[gi] ? `CPM_FN_POS
                                             : `CPM_FN_PORT;
        end
    endgenerate

    // ***********************************************************
    // Comparator 4 pins
    // ***********************************************************
    // Pin 4 serves as a negative input only while comparator 4
    // runs; a code pointing other comparators at it is not
    // honoured with comparator 4 off
    always @* begin
        if (cmp_on[3] && neg_used[3]) begin
            p66_fn = `CPM_FN_NEG;
        end else if (mouse_mode_in && counter_a_second_input_en_in) begin
            p66_fn = `CPM_FN_ALT;
        end else begin
            p66_fn = `CPM_FN_PORT;
        end
    end

    // ***********************************************************
    // Comparator 3 pins
    // ***********************************************************
    // Mouse mode forces the counter only with comparator 3 off
    always @* begin
        if (cmp_on[2]) begin
            if (neg_used[2]) begin
                p61_fn = `CPM_FN_NEG;
            end else if (counter_a_input_select_in) begin
                p61_fn = `CPM_FN_ALT;
            end else begin
                p61_fn = `CPM_FN_PORT;
            end
        end else if (mouse_mode_in || counter_a_input_select_in) begin
            p61_fn = `CPM_FN_ALT;
        end else begin
            p61_fn = `CPM_FN_PORT;
        end
    end

    // ***********************************************************
    // Comparator 2 pins
    // ***********************************************************
    // Same limitation as comparator 4 with comparator 2 off
    always @* begin
        if (cmp_on[1] && neg_used[1]) begin
            p54_fn = `CPM_FN_NEG;
        end else if (timer_source_select_in) begin
            p54_fn = `CPM_FN_ALT;
        end else begin
            p54_fn = `CPM_FN_PORT;
        end
    end

    // ***********************************************************
    // Comparator 1 pins
    // ***********************************************************
    // Code-option bits are static, so they need no synchroniser
    assign osc_is_port = (osc_option_in == `CPM_OSC_PORT);

    always @* begin
        if (cmp_on[0] && neg_used[0]) begin
            p55_fn = `CPM_FN_NEG;
        end else if (osc_is_port) begin
            p55_fn = `CPM_FN_PORT;
        end else begin
            p55_fn = `CPM_FN_ALT;
        end
    end

    // Counter-B primary input only while comparator 1 is off
    always @* begin
        if (cmp_on[0]) begin
            p51_fn = route_fn[0];
        end else if (mouse_mode_in || counter_b_input_select_in) begin
            p51_fn = `CPM_FN_ALT;
        end else begin
            p51_fn = `CPM_FN_PORT;
        end
    end

    // Second counter-B input uses a code of its own
    always @* begin
        if (cmp_on[0]) begin
            p50_fn = `CPM_FN_POS;
        end else if (mouse_mode_in && counter_b_second_input_en_in) begin
            p50_fn = `CPM_FN_ALT2;
        end else begin
            p50_fn = `CPM_FN_PORT;
        end
    end

    // ***********************************************************
    // Register reads
    // ***********************************************************
    // Unmapped addresses read as zero
    always @* begin
        rdata_next = `CPM_ZERO8;
        if (reg_rd_in) begin
            case (reg_addr_in)
                `CPM_ADDR_CTRL: begin
                    rdata_next = ctrl_reg;
                end
                `CPM_ADDR_COMBINE: begin
                    rdata_next = {`CPM_ZERO4, combine_reg};
                end
                `CPM_ADDR_FLAGS: begin
                    rdata_next = {`CPM_ZERO4, flag_reg};
                end
                `CPM_ADDR_CMPOUT: begin
                    rdata_next = {`CPM_ZERO4, sync2_reg};
                end
                `CPM_ADDR_PINUSE: begin
                    rdata_next = {route_act, neg_used};
                end
                default: begin
                    rdata_next = `CPM_ZERO8;
                end
            endcase
        end
    end

    // Data stand only in the cycle after the read strobe
    always @(posedge ref_clk_in) begin
        if (srst_in) begin
            rdata_reg <= `CPM_ZERO8;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // ***********************************************************
    // Outputs
    // ***********************************************************
    // Pin codes are combinational so a write acts next cycle
    assign reg_rdata_out       = rdata_reg;
    assign cmp_on_out          = cmp_on;
    assign cmp_neg_source_out  = src_reg;
    assign cmp_change_flag_out = flag_reg;
    assign cmp_drive_out       = drive_reg;

    // ***********************************************************
    // Pin function outputs
    // ***********************************************************

    assign port5_line1_fn_out  = p51_fn;
    assign port5_line2_fn_out  = route_fn[1];
    assign port6_line3_fn_out  = route_fn[2];
    assign port6_line4_fn_out  = route_fn[3];

    assign port5_line0_fn_out  = p50_fn;
    assign port5_line3_fn_out  = pos_fn[1];
    assign port6_line2_fn_out  = pos_fn[2];
    assign port6_line5_fn_out  = pos_fn[3];

    assign port5_line5_fn_out  = p55_fn;
    assign port5_line4_fn_out  = p54_fn;
    assign port6_line1_fn_out  = p61_fn;
    assign port6_line6_fn_out  = p66_fn;

endmodule // cpm_comparator_pin_mux

// File: common/cpm_defs.vh
// Constants for the comparator pin multiplexer
`ifndef CPM_DEFS_VH
`define CPM_DEFS_VH

// ***************************************************************
// Register map
// ***************************************************************
`define CPM_ADDR_W        3
`define CPM_DATA_W        8
`define CPM_ADDR_CTRL     3'h0
`define CPM_ADDR_COMBINE  3'h1
`define CPM_ADDR_FLAGS    3'h2
`define CPM_ADDR_CMPOUT   3'h3
`define CPM_ADDR_PINUSE   3'h4
`define CPM_CTRL_RST      8'h00
`define CPM_COMBINE_RST   4'h0
`define CPM_ZERO8         8'h00
`define CPM_ZERO4         4'h0

// ***************************************************************
// Field layout
// ***************************************************************
`define CPM_NCMP          4
`define CPM_ON_MSB        3
`define CPM_ON_LSB        0
`define CPM_ROUTE_MSB     7
`define CPM_ROUTE_LSB     4
`define CPM_CODE_MSB      3
`define CPM_CODE_LSB      0
`define CPM_SRC_W         2
`define CPM_OSC_PORT      3'h7

// ***************************************************************
// Pin function codes
// ***************************************************************
`define CPM_FN_W          3
`define CPM_FN_PORT       3'h0
`define CPM_FN_CMP_OUT    3'h1
`define CPM_FN_NEG        3'h2
`define CPM_FN_POS        3'h3
`define CPM_FN_ALT        3'h4
`define CPM_FN_ALT2       3'h5

`endif

// File: verilog/cpm_combine_decode.v
// Decoder from combine code to shared negative-input layout
`timescale 1ns/10ps
`include "cpm_defs.vh"

module cpm_combine_decode (
    // Next code of the combine register
    input  wire [`CPM_CODE_MSB:0]  code_in,
    // Negative pins that stay analog inputs
    output wire [`CPM_NCMP-1:0]    keep_out,
    // Two bits per comparator: pin its negative input uses
    output wire [7:0]              source_out
);

    reg [11:0] entry;

    // Upper nibble keep mask, lower byte sources (cmp4 on top)
    always @* begin
        case (code_in)
            4'h0: entry = 12'hfe4;
            4'h1: entry = 12'hee5;
            4'h2: entry = 12'hee6;
            4'h3: entry = 12'hee7;
            4'h4: entry = 12'hde8;
            4'h5: entry = 12'hdec;
            4'h6: entry = 12'hbf4;
            4'h7: entry = 12'hcea;
            4'h8: entry = 12'hcef;
            4'h9: entry = 12'haf7;
            4'ha: entry = 12'h9fc;
            4'hb: entry = 12'h8ff;
            4'hc: entry = 12'hbd4;
            4'hd: entry = 12'h764;
            4'he: entry = 12'h354;
            4'hf: entry = 12'h6a6;
            default: entry = 12'hfe4;
        endcase
    end

    assign keep_out   = entry[11:8];
    assign source_out = entry[7:0];

endmodule // cpm_combine_decode

// File: testbench/cpm_pin_mux_checker.sv
// Port-level assertions for the comparator pin multiplexer
`timescale 1ns/10ps
`include "cpm_defs.vh"

module cpm_pin_mux_checker (
    // Clock and reset
    input wire                   ref_clk_in,
    input wire                   srst_in,
    // Register port
    input wire [`CPM_ADDR_W-1:0] reg_addr_in,
    input wire [`CPM_DATA_W-1:0] reg_wdata_in,
    input wire                   reg_wr_in,
    // Mode settings
    input wire                   mouse_mode_in,
    input wire                   counter_a_second_input_en_in,
    input wire                   counter_b_second_input_en_in,
    input wire                   counter_a_input_select_in,
    input wire                   timer_source_select_in,
    input wire [2:0]             osc_option_in,
    // Comparators and pins
    input wire [`CPM_NCMP-1:0]   cmp_raw_in,
    input wire [`CPM_NCMP-1:0]   cmp_on_out,
    input wire [`CPM_NCMP-1:0]   cmp_change_flag_out,
    input wire [`CPM_FN_W-1:0]   port5_line1_fn_out,
    input wire [`CPM_FN_W-1:0]   port6_line4_fn_out,
    input wire [`CPM_FN_W-1:0]   port5_line0_fn_out,
    input wire [`CPM_FN_W-1:0]   port6_line5_fn_out,
    input wire [`CPM_FN_W-1:0]   port5_line5_fn_out,
    input wire [`CPM_FN_W-1:0]   port5_line4_fn_out,
    input wire [`CPM_FN_W-1:0]   port6_line1_fn_out,
    input wire [`CPM_FN_W-1:0]   port6_line6_fn_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);

    chk_on_write: assert property (
        reg_wr_in && reg_addr_in == `CPM_ADDR_CTRL
        |=> cmp_on_out == $past(reg_wdata_in[3:0]))
        else $error("enable bits differ from written control value");
    chk_route_one: assert property (
        port5_line1_fn_out == `CPM_FN_CMP_OUT |-> cmp_on_out[0])
        else $error("line 5.1 routed while off");
    chk_route_four: assert property (
        port6_line4_fn_out == `CPM_FN_CMP_OUT |-> cmp_on_out[3])
        else $error("line 6.4 routed while off");
    chk_pos_four: assert property (
        cmp_on_out[3] |-> port6_line5_fn_out == `CPM_FN_POS)
        else $error("positive pin of comparator 4 not dedicated");
    chk_pos_one: assert property (
        cmp_on_out[0] |-> port5_line0_fn_out == `CPM_FN_POS)
        else $error("positive pin of comparator 1 not dedicated");
    chk_cmp4_off: assert property (
        !cmp_on_out[3] |-> port6_line6_fn_out ==
        ((mouse_mode_in && counter_a_second_input_en_in) ?
        `CPM_FN_ALT : `CPM_FN_PORT))
        else $error("line 6.6 function wrong");
    chk_cmp3_off: assert property (
        !cmp_on_out[2] |-> port6_line1_fn_out ==
        ((mouse_mode_in || counter_a_input_select_in) ?
        `CPM_FN_ALT : `CPM_FN_PORT))
        else $error("line 6.1 function wrong");
    chk_cmp2_off: assert property (
        !cmp_on_out[1] |-> port5_line4_fn_out ==
        (timer_source_select_in ? `CPM_FN_ALT : `CPM_FN_PORT))
        else $error("line 5.4 function wrong");
    chk_cmp1_off: assert property (
        !cmp_on_out[0] |-> port5_line0_fn_out ==
        ((mouse_mode_in && counter_b_second_input_en_in) ?
        `CPM_FN_ALT2 : `CPM_FN_PORT))
        else $error("line 5.0 function wrong");
    chk_osc_select: assert property (
        !cmp_on_out[0] |-> port5_line5_fn_out ==
        ((osc_option_in == `CPM_OSC_PORT) ? `CPM_FN_PORT : `CPM_FN_ALT))
        else $error("line 5.5 function wrong");
    chk_flag_set: assert property (
        $rose(cmp_raw_in[0]) && cmp_on_out[0]
        |-> ##[2:4] cmp_change_flag_out[0])
        else $error("change flag of comparator 1 not set");
endmodule // cpm_pin_mux_checker

// File: testbench/tb.sv
// Register-level testbench for the comparator pin multiplexer
`timescale 1ns/10ps
`include "cpm_defs.vh"

module tb;
    // Combine code to negative source, code 0 in the low byte
    localparam [127:0] SRC_TBL =
        128'hA654_64D4_FFFC_F7EF_EAF4_ECE8_E7E6_E5E4;
    reg        ref_clk_in = 1'b0;
    reg        srst_in = 1'b1;
    reg  [2:0] reg_addr_in = 3'h0;
    reg  [7:0] reg_wdata_in = 8'h00;
    reg        reg_wr_in = 1'b0;
    reg        reg_rd_in = 1'b0;
    reg        mouse = 1'b0, a2en = 1'b0, b2en = 1'b0;
    reg        asel = 1'b0, bsel = 1'b0, ts = 1'b0;
    reg  [2:0] osc = 3'h7;
    reg  [3:0] cmp_raw_in = 4'h0;
    wire [7:0] reg_rdata_out, neg_src;
    wire [3:0] on, flag, drive;
    wire [2:0] p51, p64, p50, p65, p55, p54, p61, p66;
    wire [2:0] p52, p63, p53, p62;
    integer    errors = 0;
    integer    num_checks = 0;
    integer    i, j;
    reg  [7:0] src;
    reg  [3:0] used;

    always #10 ref_clk_in = ~ref_clk_in;

    cpm_comparator_pin_mux cpm_comparator_pin_mux_inst (
        .ref_clk_in(ref_clk_in), .srst_in(srst_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .mouse_mode_in(mouse),
        .counter_a_second_input_en_in(a2en),
        .counter_b_second_input_en_in(b2en),
        .counter_a_input_select_in(asel), .counter_b_input_select_in(bsel),
        .timer_source_select_in(ts), .osc_option_in(osc),
        .cmp_raw_in(cmp_raw_in), .cmp_on_out(on),
        .cmp_neg_source_out(neg_src), .cmp_change_flag_out(flag),
        .cmp_drive_out(drive), .port5_line1_fn_out(p51),
        .port5_line2_fn_out(p52), .port6_line3_fn_out(p63),
        .port6_line4_fn_out(p64), .port5_line0_fn_out(p50),
        .port5_line3_fn_out(p53), .port6_line2_fn_out(p62),
        .port6_line5_fn_out(p65), .port5_line5_fn_out(p55),
        .port5_line4_fn_out(p54), .port6_line1_fn_out(p61),
        .port6_line6_fn_out(p66));

    task chk(input string name, input [7:0] exp, input [7:0] got);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("ERROR %0s expected %h seen %h", name, exp, got);
            end
        end
    endtask

    task chk_fn(input string name, input [2:0] exp, input [2:0] got);
        chk(name, {5'h00, exp}, {5'h00, got});
    endtask

    // Strobe ends one edge after it rose, so calls never collide
    task wr(input [2:0] a, input [7:0] d);
        begin
            @(posedge ref_clk_in);
            reg_addr_in  <= a;
            reg_wdata_in <= d;
            reg_wr_in    <= 1'b1;
            @(posedge ref_clk_in);
            reg_wr_in    <= 1'b0;
            #1;
        end
    endtask

    task rd(input [2:0] a, input [7:0] exp, input string name);
        begin
            @(posedge ref_clk_in);
            reg_addr_in <= a;
            reg_rd_in   <= 1'b1;
            @(posedge ref_clk_in);
            reg_rd_in   <= 1'b0;
            #1;
            chk(name, exp, reg_rdata_out);
        end
    endtask

    task rst_seq;
        begin
            @(posedge ref_clk_in);
            srst_in <= 1'b1;
            repeat (4) @(posedge ref_clk_in);
            srst_in <= 1'b0;
        end
    endtask

    task stop_test;
        begin
            $display("checks %0d errors %0d", num_checks, errors);
            if (errors == 0 && num_checks > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask

    initial begin
        #200000;
        errors = errors + 1;
        stop_test;
    end

    initial begin
        rst_seq;
        rd(`CPM_ADDR_CTRL, `CPM_CTRL_RST, "ctrl");
        rd(`CPM_ADDR_COMBINE, `CPM_ZERO8, "combine");
        rd(`CPM_ADDR_FLAGS, `CPM_ZERO8, "flags");
        wr(3'h7, 8'hFF);
        chk("on", 8'h00, {4'h0, on});
        rd(3'h7, `CPM_ZERO8, "unmapped");
        $display("test reset done");
        wr(`CPM_ADDR_CTRL, 8'h11);
        chk_fn("p51", `CPM_FN_CMP_OUT, p51);
        chk_fn("p50", `CPM_FN_POS, p50);
        chk_fn("p64", `CPM_FN_PORT, p64);
        rd(`CPM_ADDR_CTRL, 8'h11, "ctrl");
        wr(`CPM_ADDR_CTRL, 8'h87);
        chk_fn("p64", `CPM_FN_PORT, p64);
        chk_fn("p51", `CPM_FN_PORT, p51);
        chk("on", 8'h07, {4'h0, on});
        chk_fn("p53", `CPM_FN_POS, p53);
        chk_fn("p62", `CPM_FN_POS, p62);
        chk_fn("p52", `CPM_FN_PORT, p52);
        chk_fn("p63", `CPM_FN_PORT, p63);
        wr(`CPM_ADDR_CTRL, 8'h66);
        chk_fn("p52", `CPM_FN_CMP_OUT, p52);
        chk_fn("p63", `CPM_FN_CMP_OUT, p63);
        chk_fn("p64", `CPM_FN_PORT, p64);
        wr(`CPM_ADDR_CTRL, 8'h88);
        chk_fn("p64", `CPM_FN_CMP_OUT, p64);
        chk_fn("p53", `CPM_FN_PORT, p53);
        chk_fn("p65", `CPM_FN_POS, p65);
        $display("test control done");
        @(posedge ref_clk_in);
        ts <= 1'b1;
        wr(`CPM_ADDR_CTRL, 8'h0F);
        for (i = 0; i < 16; i = i + 1) begin
            wr(`CPM_ADDR_COMBINE, {4'hF, i[3:0]});
            src = SRC_TBL[i*8 +: 8];
            used = 4'h0;
            for (j = 0; j < 4; j = j + 1)
                used[src[j*2 +: 2]] = 1'b1;
            chk("neg_src", src, neg_src);
            chk_fn("p55", used[0] ? `CPM_FN_NEG : `CPM_FN_PORT, p55);
            chk_fn("p54", used[1] ? `CPM_FN_NEG : `CPM_FN_ALT, p54);
            chk_fn("p61", used[2] ? `CPM_FN_NEG : `CPM_FN_PORT, p61);
            chk_fn("p66", used[3] ? `CPM_FN_NEG : `CPM_FN_PORT, p66);
            rd(`CPM_ADDR_COMBINE, {4'h0, i[3:0]}, "combine");
        end
        $display("test combine done");
        wr(`CPM_ADDR_CTRL, 8'h00);
        for (i = 0; i < 64; i = i + 1) begin
            @(posedge ref_clk_in);
            {mouse, a2en, b2en, asel, bsel, ts} <= i[5:0];
            osc <= i[2:0];
            #1;
            chk_fn("p51", (i[5] | i[1]) ? `CPM_FN_ALT : `CPM_FN_PORT, p51);
        end
        @(posedge ref_clk_in);
        {mouse, a2en, b2en, asel, bsel, ts} <= 6'h00;
        osc <= 3'h7;
        $display("test modes done");
        wr(`CPM_ADDR_CTRL, 8'h11);
        @(posedge ref_clk_in);
        cmp_raw_in <= 4'h3;
        repeat (5) @(posedge ref_clk_in);
        #1;
        chk("drive", 8'h01, {4'h0, drive});
        rd(`CPM_ADDR_CMPOUT, 8'h03, "cmpout");
        rd(`CPM_ADDR_PINUSE, 8'h14, "pinuse");
        rd(`CPM_ADDR_FLAGS, 8'h01, "flags");
        wr(`CPM_ADDR_FLAGS, 8'h01);
        rd(`CPM_ADDR_FLAGS, `CPM_ZERO8, "flags");
        $display("test flags done");
        rst_seq;
        rd(`CPM_ADDR_CTRL, `CPM_CTRL_RST, "ctrl");
        chk("on", 8'h00, {4'h0, on});
        $display("test second reset done");
        stop_test;
    end
endmodule // tb

bind cpm_comparator_pin_mux cpm_pin_mux_checker cpm_pin_mux_checker_inst (
    .ref_clk_in, .srst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .mouse_mode_in, .counter_a_second_input_en_in,
    .counter_b_second_input_en_in, .counter_a_input_select_in,
    .timer_source_select_in, .osc_option_in, .cmp_raw_in, .cmp_on_out,
    .cmp_change_flag_out, .port5_line1_fn_out, .port6_line4_fn_out,
    .port5_line0_fn_out, .port6_line5_fn_out, .port5_line5_fn_out,
    .port5_line4_fn_out, .port6_line1_fn_out, .port6_line6_fn_out);
